//--- cwt_decoder.sv
// Module: configuration word two decoder with AXI4-Lite register access
`timescale 1ns/1ps
// Behaviour
// - Bit13 zero demands high-voltage programming entry
// - Bit12 one frees debug pins as I/O
// - Bit11 zero enables low-power brown-out
// - Bit10 one low trip, zero high
// - Two-bit field sizes self-write protected region
module cwt_decoder
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        rvalid_unused_n,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        hv_on_master_clear,
  input  wire logic        lv_entry_seq,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  output logic             prog_entry,
  output logic             low_volt_prog_enable,
  output logic             debug_pins_gpio,
  output logic             low_power_brownout_on,
  output logic             brownout_threshold_low,
  output logic             stack_fault_reset,
  output logic             zero_cross_detector_on,
  output logic             clock_multiplier_enable,
  output logic             pin_select_lock_once,
  output logic             wp_active,
  output logic [11:0]      wp_end_addr
);

  // Write and read channel state
  logic        aw_held_q;
  logic        aw_held_d;
  logic [3:0]  aw_addr_q;
  logic [3:0]  aw_addr_d;
  logic        w_held_q;
  logic        w_held_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0]  w_strb_q;
  logic [3:0]  w_strb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;

  // Register state
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  logic        zsen_q;
  logic        zsen_d;

  // Pin synchronisers
  logic [3:0]  pin_s1_q;
  logic [3:0]  pin_s2_q;

  // Decoded outputs
  logic [7:0]  dec_q;
  logic [7:0]  dec_d;

  logic        aw_fire;
  logic        w_fire;
  logic        do_write;
  logic        ar_fire;

  function automatic logic [13:0] merge_cfg(input logic [13:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [13:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[13:8] = data[13:8];
    merge_cfg = res | cwt_pkg::UNIMP_MSK;
  endfunction : merge_cfg

  assign awready  = !aw_held_q && !bvalid_q;
  assign wready   = !w_held_q && !bvalid_q;
  assign aw_fire  = awvalid && awready;
  assign w_fire   = wvalid && wready;
  assign do_write = (aw_held_q || aw_fire) && (w_held_q || w_fire);
  assign arready  = !rvalid_q;
  assign ar_fire  = arvalid && arready;

  always_comb
  begin
    logic [3:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    wa = aw_held_q ? aw_addr_q : awaddr;
    wd = w_held_q ? w_data_q : wdata;
    ws = w_held_q ? w_strb_q : wstrb;
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    cfg_d     = cfg_q;
    zsen_d    = zsen_q;
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (aw_fire)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (w_fire)
    begin
      w_held_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (do_write)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = cwt_pkg::RESP_OKAY;
      case (wa)
        cwt_pkg::OFF_CFG:  cfg_d = merge_cfg(cfg_q, wd, ws);
        cwt_pkg::OFF_CTRL:
        begin
          if (ws[0])
            zsen_d = wd[cwt_pkg::BIT_ZSEN];
        end
        cwt_pkg::OFF_STATUS: bresp_d = cwt_pkg::RESP_SLVERR;
        default:             bresp_d = cwt_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (ar_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d  = cwt_pkg::RESP_OKAY;
      case (araddr)
        cwt_pkg::OFF_CFG:    rdata_d = {18'h0_0000, cfg_q};
        cwt_pkg::OFF_CTRL:   rdata_d = {31'h0000_0000, zsen_q};
        cwt_pkg::OFF_STATUS: rdata_d = {18'h0_0000, wp_end_addr, wp_active, dec_q[1]};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = cwt_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Decode configuration bits, gated by synchronised pins and zsen for entry, stack reset and zero-cross, into enables
  always_comb
  begin
    dec_d    = 8'h00;
    dec_d[0] = cfg_q[cwt_pkg::BIT_LOW_VOLT];
    dec_d[1] = cfg_q[cwt_pkg::BIT_LOW_VOLT] ? (pin_s2_q[0] || pin_s2_q[1]) : pin_s2_q[0];
    dec_d[2] = cfg_q[cwt_pkg::BIT_DBG];
    dec_d[3] = !cfg_q[cwt_pkg::BIT_LP_BROWN];
    dec_d[4] = cfg_q[cwt_pkg::BIT_TRIP];
    dec_d[5] = cfg_q[cwt_pkg::BIT_STK] && (pin_s2_q[2] || pin_s2_q[3]);
    dec_d[6] = cfg_q[cwt_pkg::BIT_ZERO_CROSS] ? zsen_q : 1'b1;
    dec_d[7] = cfg_q[cwt_pkg::BIT_PLL];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'b00;
      cfg_q     <= cwt_pkg::CFG_RST;
      zsen_q    <= 1'b0;
      pin_s1_q  <= 4'h0;
      pin_s2_q  <= 4'h0;
      dec_q     <= 8'h00;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      cfg_q     <= cfg_d;
      zsen_q    <= zsen_d;
      pin_s1_q  <= {stack_underflow, stack_overflow, lv_entry_seq, hv_on_master_clear};
      pin_s2_q  <= pin_s1_q;
      dec_q     <= dec_d;
    end
  end

  cwt_wp_decode i_cwt_wp_decode
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wp_field    (cfg_q[cwt_pkg::BIT_SELF_WP +: 2]),
    .wp_active   (wp_active),
    .wp_end_addr (wp_end_addr)
  );

  assign bvalid                  = bvalid_q;
  assign bresp                   = bresp_q;
  assign rvalid                  = rvalid_q;
  assign rdata                   = rdata_q;
  assign rresp                   = rresp_q;
  assign low_volt_prog_enable    = dec_q[0];
  assign prog_entry              = dec_q[1];
  assign debug_pins_gpio         = dec_q[2];
  assign low_power_brownout_on   = dec_q[3];
  assign brownout_threshold_low  = dec_q[4];
  assign stack_fault_reset       = dec_q[5];
  assign zero_cross_detector_on  = dec_q[6];
  assign clock_multiplier_enable = dec_q[7];
  assign pin_select_lock_once    = cfg_q[cwt_pkg::BIT_PPS];

  // Assertions
  property p_lv_allow;
    @(posedge aclk) disable iff (!aresetn)
      (cfg_q[cwt_pkg::BIT_LOW_VOLT] && pin_s2_q[1]) |=> prog_entry;
  endproperty
  a_lv_allow: assert property (p_lv_allow) else $error("Low-voltage entry refused");

  property p_lv_block;
    @(posedge aclk) disable iff (!aresetn)
      (!cfg_q[cwt_pkg::BIT_LOW_VOLT] && !pin_s2_q[0]) |=> !prog_entry;
  endproperty
  a_lv_block: assert property (p_lv_block) else $error("Entry without high voltage");

  property p_dbg;
    @(posedge aclk) disable iff (!aresetn)
      aresetn |=> (debug_pins_gpio == $past(cfg_q[cwt_pkg::BIT_DBG]));
  endproperty
  a_dbg: assert property (p_dbg) else $error("Debug pin ownership wrong");

  property p_lp_brown;
    @(posedge aclk) disable iff (!aresetn)
      aresetn |=> (low_power_brownout_on == !$past(cfg_q[cwt_pkg::BIT_LP_BROWN]));
  endproperty
  a_lp_brown: assert property (p_lp_brown) else $error("Low-power brown-out wrong");

  property p_trip;
    @(posedge aclk) disable iff (!aresetn)
      aresetn |=> (brownout_threshold_low == $past(cfg_q[cwt_pkg::BIT_TRIP]));
  endproperty
  a_trip: assert property (p_trip) else $error("Trip select wrong");

  property p_zc_on;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_q[cwt_pkg::BIT_ZERO_CROSS] |=> zero_cross_detector_on;
  endproperty
  a_zc_on: assert property (p_zc_on) else $error("Detector not forced on");

  property p_zc_soft;
    @(posedge aclk) disable iff (!aresetn)
      (cfg_q[cwt_pkg::BIT_ZERO_CROSS] && !zsen_q) |=> !zero_cross_detector_on;
  endproperty
  a_zc_soft: assert property (p_zc_soft) else $error("Detector on without enable");

  property p_stk;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_q[cwt_pkg::BIT_STK] |=> !stack_fault_reset;
  endproperty
  a_stk: assert property (p_stk) else $error("Stack reset while disabled");

  property p_stk_fire;
    @(posedge aclk) disable iff (!aresetn)
      (stack_overflow && cfg_q[cwt_pkg::BIT_STK]) ##1 cfg_q[cwt_pkg::BIT_STK]
        ##1 cfg_q[cwt_pkg::BIT_STK] |=> stack_fault_reset;
  endproperty
  a_stk_fire: assert property (p_stk_fire) else $error("Stack fault reset missing");

  property p_wp_none;
    @(posedge aclk) disable iff (!aresetn)
      (cfg_q[cwt_pkg::BIT_SELF_WP +: 2] == cwt_pkg::CWT_WP_OFF) |=> !wp_active;
  endproperty
  a_wp_none: assert property (p_wp_none) else $error("Protection active when off");
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) ar_fire ##1 rvalid);
  c_stk: cover property (@(posedge aclk) disable iff (!aresetn) stack_fault_reset);
  c_lv_entry: cover property (@(posedge aclk) disable iff (!aresetn) prog_entry && low_volt_prog_enable);

endmodule : cwt_decoder

//--- cwt_pkg.sv
// Package: constants for the configuration word two decoder
package cwt_pkg;

  localparam int unsigned CFG_W = 14;

  // Register byte offsets
  localparam logic [3:0] OFF_CFG    = 4'h0;
  localparam logic [3:0] OFF_CTRL   = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;

  // Field positions in config_word_two
  localparam int unsigned BIT_LOW_VOLT   = 13;
  localparam int unsigned BIT_DBG        = 12;
  localparam int unsigned BIT_LP_BROWN   = 11;
  localparam int unsigned BIT_TRIP       = 10;
  localparam int unsigned BIT_STK        = 9;
  localparam int unsigned BIT_PLL        = 8;
  localparam int unsigned BIT_ZERO_CROSS = 7;
  localparam int unsigned BIT_PPS        = 2;
  localparam int unsigned BIT_SELF_WP    = 0;

  // Control register field positions
  localparam int unsigned BIT_ZSEN  = 0;

  // Reset values: blank device reads all ones
  localparam logic [13:0] CFG_RST   = 14'h3FFF;
  localparam logic [13:0] UNIMP_MSK = 14'h0078;

  // Self-write protection sizes
  typedef enum logic [1:0] {
    CWT_WP_HALF  = 2'b00,
    CWT_WP_QUART = 2'b01,
    CWT_WP_BOOT  = 2'b10,
    CWT_WP_OFF   = 2'b11
  } cwt_wp_t;

  localparam logic [11:0] WP_END_BOOT  = 12'h1FF;
  localparam logic [11:0] WP_END_QUART = 12'h7FF;
  localparam logic [11:0] WP_END_HALF  = 12'hFFF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : cwt_pkg

//--- cwt_wp_decode.sv
// Module: self-write protection range decoder
`timescale 1ns/1ps
module cwt_wp_decode
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  wp_field,
  output logic             wp_active,
  output logic [11:0]      wp_end_addr
);

  logic        act_d;
  logic        act_q;
  logic [11:0] end_d;
  logic [11:0] end_q;

  always_comb
  begin
    act_d = 1'b1;
    end_d = 12'h000;
    case (cwt_pkg::cwt_wp_t'(wp_field))
      cwt_pkg::CWT_WP_BOOT:  end_d = cwt_pkg::WP_END_BOOT;
      cwt_pkg::CWT_WP_QUART: end_d = cwt_pkg::WP_END_QUART;
      cwt_pkg::CWT_WP_HALF:  end_d = cwt_pkg::WP_END_HALF;
      default:               act_d = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_q <= 1'b0;
      end_q <= 12'h000;
    end
    else
    begin
      act_q <= act_d;
      end_q <= end_d;
    end
  end

  assign wp_active   = act_q;
  assign wp_end_addr = end_q;

  property p_wp_off;
    @(posedge aclk) disable iff (!aresetn)
      (wp_field == cwt_pkg::CWT_WP_OFF) |=> !wp_active;
  endproperty
  a_wp_off: assert property (p_wp_off) else $error("Protection not off");

  property p_wp_boot;
    @(posedge aclk) disable iff (!aresetn)
      (wp_field == cwt_pkg::CWT_WP_BOOT) |=> (wp_active && wp_end_addr == cwt_pkg::WP_END_BOOT);
  endproperty
  a_wp_boot: assert property (p_wp_boot) else $error("Boot range wrong");

endmodule : cwt_wp_decode

//--- cwt_decoder_test.sv
// Testbench for the configuration word two decoder
`timescale 1ns/1ps
module cwt_decoder_test;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hv_on_master_clear, lv_entry_seq;
  logic        stack_overflow, stack_underflow, prog_entry, low_volt_prog_enable;
  logic        debug_pins_gpio, low_power_brownout_on, brownout_threshold_low;
  logic        stack_fault_reset, zero_cross_detector_on, clock_multiplier_enable;
  logic        pin_select_lock_once, wp_active;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic [11:0] wp_end_addr;
  int          n_mismatch, checks;
  logic [13:0] cfg_tab [5] = '{14'h0000, 14'h2A84, 14'h1545, 14'h3FFE, 14'h3FFF};

  cwt_decoder i_cwt_decoder
  (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid_unused_n(1'b0), .rvalid, .rready, .rdata, .rresp,
    .hv_on_master_clear, .lv_entry_seq, .stack_overflow, .stack_underflow, .prog_entry,
    .low_volt_prog_enable, .debug_pins_gpio, .low_power_brownout_on,
    .brownout_threshold_low, .stack_fault_reset, .zero_cross_detector_on,
    .clock_multiplier_enable, .pin_select_lock_once, .wp_active, .wp_end_addr
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic guard(input int n);
    if (n >= 64)
    begin
      n_mismatch++;
      $display("[FAIL] handshake expected answer seen timeout");
      print_verdict();
    end
  endtask : guard

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int   n;
    logic aw_ok, w_ok;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    n     = 0;
    while (!(aw_ok && w_ok) && n < 64)
    begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    guard(n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 64);
    guard(n);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (arready !== 1'b1 && n < 64);
    arvalid <= 1'b0;
    guard(n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 64);
    guard(n);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic check_outputs(input logic [13:0] c, input logic zsen);
    logic [11:0] e;
    case (c[1:0])
      2'b10:   e = cwt_pkg::WP_END_BOOT;
      2'b01:   e = cwt_pkg::WP_END_QUART;
      2'b00:   e = cwt_pkg::WP_END_HALF;
      default: e = 12'h000;
    endcase
    chk("low_volt", 32'(c[13]), 32'(low_volt_prog_enable));
    chk("dbg", 32'(c[12]), 32'(debug_pins_gpio));
    chk("lp_brown", 32'(!c[11]), 32'(low_power_brownout_on));
    chk("trip_sel", 32'(c[10]), 32'(brownout_threshold_low));
    chk("zero_cross", 32'(c[7] ? zsen : 1'b1), 32'(zero_cross_detector_on));
    chk("pll", 32'(c[8]), 32'(clock_multiplier_enable));
    chk("pps", 32'(c[2]), 32'(pin_select_lock_once));
    chk("wp_act", 32'(c[1:0] != 2'b11), 32'(wp_active));
    chk("wp_end", 32'(e), 32'(wp_end_addr));
    axi_read(cwt_pkg::OFF_STATUS);
    chk("status", {18'h0, e, c[1:0] != 2'b11, 1'b0}, rd);
  endtask : check_outputs

  task automatic settle();
    repeat (5) @(posedge aclk);
  endtask : settle

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {hv_on_master_clear, lv_entry_seq, stack_overflow, stack_underflow} = 4'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h000_0000_0000;
    aresetn    = 1'b0;
    n_mismatch = 0;
    checks     = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(cwt_pkg::OFF_CFG);
    chk("cfg_rst", 32'h0000_3FFF, rd);
    axi_read(cwt_pkg::OFF_CTRL);
    chk("ctrl_rst", 32'h0000_0000, rd);
    check_outputs(14'h3FFF, 1'b0);
    $display("test reset done");
    foreach (cfg_tab[i])
    begin
      axi_write(cwt_pkg::OFF_CFG, {18'h0, cfg_tab[i]}, 4'hF);
      chk("bresp", 32'(cwt_pkg::RESP_OKAY), 32'(resp));
      settle();
      axi_read(cwt_pkg::OFF_CFG);
      chk("cfg_rd", {18'h0, cfg_tab[i] | cwt_pkg::UNIMP_MSK}, rd);
      check_outputs(cfg_tab[i], 1'b0);
    end
    axi_write(cwt_pkg::OFF_CFG, 32'h0000_0000, 4'h1);
    axi_read(cwt_pkg::OFF_CFG);
    chk("cfg_strb", 32'h0000_3F78, rd);
    $display("test decode done");
    stack_overflow <= 1'b1;
    settle();
    chk("stk_ovf", 32'h1, 32'(stack_fault_reset));
    stack_overflow  <= 1'b0;
    stack_underflow <= 1'b1;
    settle();
    chk("stk_unf", 32'h1, 32'(stack_fault_reset));
    axi_write(cwt_pkg::OFF_CFG, 32'h0000_3DFF, 4'hF);
    settle();
    chk("stk_off", 32'h0, 32'(stack_fault_reset));
    stack_underflow <= 1'b0;
    lv_entry_seq    <= 1'b1;
    settle();
    chk("lv_ok", 32'h1, 32'(prog_entry));
    axi_write(cwt_pkg::OFF_CFG, 32'h0000_1FFF, 4'hF);
    settle();
    chk("lv_refused", 32'h0, 32'(prog_entry));
    hv_on_master_clear <= 1'b1;
    settle();
    chk("hv_ok", 32'h1, 32'(prog_entry));
    $display("test pins done");
    axi_write(cwt_pkg::OFF_CTRL, 32'h0000_0001, 4'h1);
    settle();
    chk("zc_sw_on", 32'h1, 32'(zero_cross_detector_on));
    axi_write(cwt_pkg::OFF_CTRL, 32'h0000_0000, 4'h1);
    settle();
    chk("zc_sw_off", 32'h0, 32'(zero_cross_detector_on));
    axi_write(cwt_pkg::OFF_CFG, 32'h0000_1F7F, 4'hF);
    settle();
    chk("zc_always", 32'h1, 32'(zero_cross_detector_on));
    axi_write(cwt_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
    chk("ro_resp", 32'(cwt_pkg::RESP_SLVERR), 32'(resp));
    axi_read(cwt_pkg::OFF_CFG);
    chk("ro_noeff", 32'h0000_1F7F, rd);
    axi_read(4'hC);
    chk("unmap_rresp", 32'(cwt_pkg::RESP_SLVERR), 32'(resp));
    chk("unmap_rdata", 32'h0000_0000, rd);
    axi_write(4'hC, 32'h0000_0000, 4'hF);
    chk("unmap_bresp", 32'(cwt_pkg::RESP_SLVERR), 32'(resp));
    $display("test errors done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
endmodule : cwt_decoder_test
